// ===== logic/liu_ctrl_regs.sv
// AHB-Lite register bank: receive config and interrupt enable.
// Assumes a single master, whole-word transfers, zero wait states.
module liu_ctrl_regs
  import liu_regs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [6:0]  src_status,
  output logic [1:0]       rx_resistor_select,
  output logic             bpv_insert_pulse,
  output logic             irq
);
  liu_regs_if link ();                    // Strobes to event logic

  logic       wr_pend_reg, wr_pend_next;  // Write data phase pending
  logic [7:0] wr_addr_reg, wr_addr_next;  // Latched write offset
  logic [7:0] cfg_reg, cfg_next;          // Receive config register
  logic [7:0] ien_reg, ien_next;          // Interrupt enable register
  logic [31:0] rd_reg, rd_next;           // Registered read data
  logic        bpv_reg, bpv_next;         // Violation insert pulse
  logic        accept;                    // Address phase taken

  ////////////////////////////////////////////////////////////////////
  // Read decode, used for unmapped answer too
  function automatic logic [7:0] rd_decode(input logic [7:0] a,
                                           input logic [7:0] c,
                                           input logic [7:0] e,
                                           input logic [6:0] p,
                                           input logic [6:0] s);
    logic [7:0] r;
    r = reg_reset;
    unique case (a)
      rx_config_off:  r = c;
      irq_enable_off: r = e;
      irq_status_off: r = {1'b0, p};
      src_status_off: r = {1'b0, s};
      default:        r = reg_reset;  // Unmapped and clear read zero
    endcase
    return r;
  endfunction

  assign accept = hsel & htrans[1] & hready;

  ////////////////////////////////////////////////////////////////////
  // Next-state: write capture, register update, read data
  always_comb begin
    wr_pend_next = accept & hwrite;
    wr_addr_next = accept ? (haddr[7:0] & off_mask) : wr_addr_reg;
    cfg_next     = cfg_reg;
    ien_next     = ien_reg;
    bpv_next     = 1'b0;
    link.clr_we   = 1'b0;
    link.clr_data = hwdata[6:0];
    rd_next      = rd_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        rx_config_off: begin
          // Bits 7:5 not modelled, read zero
          cfg_next = hwdata[7:0] & cfg_write_mask;
          // Only a 0-to-1 change inserts one violation
          bpv_next = hwdata[insert_bpv_bit]
                     & ~cfg_reg[insert_bpv_bit];
        end
        irq_enable_off: ien_next = hwdata[7:0];
        irq_clear_off:  link.clr_we = 1'b1;
        default: ;                               // Ignored write
      endcase
    end
    if (accept && !hwrite) begin
      rd_next = {24'h000000, rd_decode(haddr[7:0], cfg_reg, ien_reg,
                 link.pending, src_status)};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= reg_reset;
      cfg_reg     <= reg_reset;
      ien_reg     <= reg_reset;
      rd_reg      <= 32'h00000000;
      bpv_reg     <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      cfg_reg     <= cfg_next;
      ien_reg     <= ien_next;
      rd_reg      <= rd_next;
      bpv_reg     <= bpv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-source masks; bit 6 driver .. bit 0 test pattern
  assign link.mask = ien_reg[6:0];
  // Masks gate only the pin; flags set regardless of mask

  liu_irq_events u_events (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .src_status (src_status),
    .bus        (link)
  );

  // Pin needs global gate and one enabled pending flag
  assign irq = ien_reg[global_bit]
               & |(link.pending & link.mask);

  assign hrdata             = rd_reg;
  assign hreadyout          = 1'b1;  // Never waits
  assign hresp              = 1'b0;  // Always OKAY
  assign rx_resistor_select = {cfg_reg[res_hi_bit],
                               cfg_reg[res_lo_bit]};
  assign bpv_insert_pulse   = bpv_reg;
endmodule // liu_ctrl_regs

// ===== logic/liu_regs_pkg.sv
// Constants for the line-interface control register bank.
// Assumes a single AHB-Lite slave on hclk with active-low async reset.
package liu_regs_pkg;
  // Byte offsets on the bus
  localparam logic [7:0] rx_config_off   = 8'h0c;
  localparam logic [7:0] irq_enable_off  = 8'h04;
  localparam logic [7:0] irq_status_off  = 8'h14;
  localparam logic [7:0] irq_clear_off   = 8'h18;
  localparam logic [7:0] src_status_off  = 8'h1c;
  localparam logic [7:0] off_mask        = 8'hff;
  // Field positions
  localparam int global_bit      = 7;
  localparam int insert_bpv_bit  = 2;
  localparam int res_hi_bit      = 4;
  localparam int res_lo_bit      = 3;
  localparam int n_src           = 7;
  // Reset values and masks
  localparam logic [7:0] reg_reset       = 8'h00;
  localparam logic [7:0] cfg_write_mask  = 8'h1f;
  localparam logic [6:0] src_reset       = 7'h00;
  // Resistor select encodings
  typedef enum logic [1:0] {
    res_none = 2'b00,
    res_60   = 2'b01,
    res_52p5 = 2'b10,
    res_37p5 = 2'b11
  } rx_res_e;
endpackage

// ===== logic/liu_regs_if.sv
// Write strobe group shared between bus slave and event logic.
// Assumes one hclk domain.
interface liu_regs_if;
  logic       clr_we;   // One-cycle clear strobe
  logic [6:0] clr_data; // Bits to clear
  logic [6:0] mask;     // Source enables
  logic [6:0] pending;  // Sticky flags
  modport regs (output clr_we, output clr_data, output mask,
                input pending);
  modport evt  (input clr_we, input clr_data, input mask,
                output pending);
endinterface

// ===== logic/liu_irq_events.sv
// Sticky interrupt flags fed by edges of source status levels.
// Assumes status inputs synchronous to hclk.
module liu_irq_events
  import liu_regs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [6:0] src_status,
  liu_regs_if.evt         bus
);
  logic [6:0] prev_reg, prev_next;  // Last sampled status
  logic [6:0] pend_reg, pend_next;  // Sticky flags

  ////////////////////////////////////////////////////////////////////
  // Any change sets its flag; set beats a same-cycle clear
  always_comb begin
    prev_next = src_status;
    pend_next = pend_reg;
    if (bus.clr_we) begin
      pend_next = pend_next & ~bus.clr_data;
    end
    pend_next = pend_next | (src_status ^ prev_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= src_reset;
      pend_reg <= src_reset;
    end else begin
      prev_reg <= prev_next;
      pend_reg <= pend_next;
    end
  end

  assign bus.pending = pend_reg;
endmodule // liu_irq_events

// ===== tb/liu_ctrl_regs_chk.sv
// Port checker for the control register bank.
// Assumes one hclk domain; bound into every bank instance.
module liu_ctrl_regs_chk
  import liu_regs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [6:0]  src_status,
  input wire logic [1:0]  rx_resistor_select,
  input wire logic        bpv_insert_pulse,
  input wire logic        irq
);
  logic       wcfg_reg, wen_reg, ins_reg; // Data phase flags, bit 2 copy
  logic [7:0] en_reg;                     // Enable register copy
  wire        wr   = hsel & htrans[1] & hready & hwrite;
  wire        rise = wcfg_reg & hwdata[2] & !ins_reg; // Bit 2 goes 0 to 1
  // Copies change at the same edge as the bank's own registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {wcfg_reg, wen_reg, ins_reg, en_reg} <= '0;
    else begin
      wcfg_reg <= wr & haddr[7:0] == rx_config_off;
      wen_reg <= wr & haddr[7:0] == irq_enable_off;
      if (wcfg_reg) ins_reg <= hwdata[2];
      if (wen_reg) en_reg <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rise; rise |=> bpv_insert_pulse; endproperty
  a_rise: assert property (p_rise) else $error("pulse missing");
  property p_cause; bpv_insert_pulse |-> $past(rise); endproperty
  a_cause: assert property (p_cause) else $error("stray pulse");
  property p_once; bpv_insert_pulse |=> !bpv_insert_pulse; endproperty
  a_once: assert property (p_once) else $error("long pulse");
  property p_res; wcfg_reg |=> rx_resistor_select == $past(hwdata[4:3]);
  endproperty
  a_res: assert property (p_res) else $error("bad resistor");
  property p_keep; !wcfg_reg |=> $stable(rx_resistor_select); endproperty
  a_keep: assert property (p_keep) else $error("resistor moved");
  property p_glob; !en_reg[7] |-> !irq; endproperty
  a_glob: assert property (p_glob) else $error("irq ungated");
  property p_mask; en_reg[6:0] == 7'h00 |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq unmasked");
  property p_edge; en_reg[7] && $stable(en_reg) &&
    |((src_status ^ $past(src_status)) & en_reg[6:0]) |-> ##[1:2] irq;
  endproperty
  a_edge: assert property (p_edge) else $error("irq missing");
endmodule // liu_ctrl_regs_chk
bind liu_ctrl_regs liu_ctrl_regs_chk chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .src_status, .rx_resistor_select,
  .bpv_insert_pulse, .irq);

// ===== tb/test_liu_irq_enable_and_rx_config_regs.sv
// Self-checking bench for the control register bank.
// Assumes zero-wait answers; hready is fed back from hreadyout.
module test_liu_irq_enable_and_rx_config_regs
  import liu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;            // Whole words only
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [6:0]  src_status = 7'h00;     // Event source levels
  logic [1:0]  rx_resistor_select;
  logic [7:0]  d;
  logic        hreadyout, hresp, bpv_insert_pulse, irq, rd_ph = 1'b0;
  logic [31:0] exp_q[$];               // Expected read data, oldest first
  int          bad_count = 0, checked = 0, pulses = 0, seed = 7525;
  liu_ctrl_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .src_status, .rx_resistor_select, .bpv_insert_pulse, .irq);
  always #25 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single transfer; a read leaves its expectation in the queue
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] v);
    if (!w) exp_q.push_back(v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= w ? v : 32'h0;
    do @(posedge hclk); while (!hreadyout);
    if (w) @(posedge hclk); // Idle edge so output checks right after the task see the write
  endtask
  // Read data is taken mid data phase, clear of any edge race
  always @(posedge hclk) rd_ph <= hsel & htrans[1] & hreadyout & !hwrite;
  always @(negedge hclk) if (rd_ph) chk(hrdata, exp_q.pop_front());
  // Every read answer must be zero-wait and OKAY
  always @(negedge hclk) if (rd_ph) chk({hreadyout, hresp}, 32'h2);
  always @(negedge hclk) if (bpv_insert_pulse) pulses++;
  task automatic stop_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge hclk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(irq_enable_off, 1'b0, 32'h0);
    xfer(8'h20, 1'b0, 32'h0);
    repeat (4) begin
      d = 8'($random(seed));
      xfer(irq_enable_off, 1'b1, {24'h0, d});
      xfer(irq_enable_off, 1'b0, {24'h0, d});
    end
    for (int k = 0; k < 4; k++) begin
      xfer(rx_config_off, 1'b1, 32'(k) << 3);
      chk(32'(rx_resistor_select), 32'(k));
    end
    for (int i = 0; i < 4; i++) xfer(rx_config_off, 1'b1, 32'(i != 2) << 2);
    chk(32'(pulses), 32'h2);
    for (int k = 0; k < 7; k++) begin
      automatic int j = (k + 1) % 7;
      xfer(irq_enable_off, 1'b1, 32'h80 | 32'h1 << k);
      xfer(irq_clear_off, 1'b1, 32'h7f);
      src_status[j] <= ~src_status[j];
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0);
      src_status[k] <= ~src_status[k];
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h1);
      xfer(irq_status_off, 1'b0, 32'h1 << k | 32'h1 << j);
      xfer(irq_enable_off, 1'b1, 32'h1 << k);
      chk(32'(irq), 32'h0);
    end
    xfer(src_status_off, 1'b0, 32'(src_status));
    stop_test;
  end
endmodule // test_liu_irq_enable_and_rx_config_regs
